/* File: common/mas_cfg.svh */
// Constants for the memory address space access block.
// Assumes inclusion by bare name from design files only.
`ifndef MAS_CFG_SVH
`define MAS_CFG_SVH

// Program space layout, byte-style addresses
`define MAS_RESET_PC    24'h000000
`define MAS_RESET_TGT   24'h000002
`define MAS_VEC_END     24'h000200
`define MAS_IVT_LO      24'h000004
`define MAS_IVT_HI      24'h0000FF
`define MAS_AIVT_LO     24'h000104
`define MAS_AIVT_HI     24'h0001FF
`define MAS_EE_LO       24'h7FFE00
`define MAS_EE_HI       24'h7FFFFF
`define MAS_PC_STEP     24'h000002

// Data space layout
`define MAS_RAM_WORDS   15'h0400
`define MAS_NEAR_HI     16'h1FFF
`define MAS_BYTE_STEP   16'h0001
`define MAS_WORD_STEP   16'h0002

`endif

/* File: common/mas_pkg.sv */
// Types for the memory address space access block.
// Assumes nothing of its surroundings.
package mas_pkg;

   // Data address formation modes
   typedef enum logic [1:0] {
      AM_NEAR,
      AM_FULL,
      AM_IND,
      AM_IND_POSTINC
   } mas_amode_t;

   // Working register update operations
   typedef enum logic [1:0] {
      WOP_WORD,
      WOP_BYTE,
      WOP_SE,
      WOP_ZE
   } mas_wop_t;

   // Address error trap states
   typedef enum logic {
      TRAP_IDLE,
      TRAP_PEND
   } mas_trap_t;

endpackage

/* File: logic/mas_byte_lane.sv */
// One byte-wide lane of the data RAM held in flip-flops.
// Assumes a single clock; reads are combinational from the array.
`timescale 1ns/1ps

module mas_byte_lane (
   // Clock
   input  wire logic       core_clk_i,
   // Write side
   input  wire logic       wr_en_i,
   input  wire logic [9:0] wr_idx_i,
   input  wire logic [7:0] wr_byte_i,
   // Read side
   input  wire logic [9:0] rd_idx_i,
   output logic      [7:0] rd_byte_o
);

   logic [7:0] mem_reg [0:1023];

   // Lane storage, written only on its own strobe
   always_ff @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem_reg[wr_idx_i] <= wr_byte_i;
      end
   end

   // Read by index
   assign rd_byte_o = mem_reg[rd_idx_i];

endmodule

/* File: logic/mas_access.sv */
// Address space decode and access logic: program counter, program and
// table access, data address generators, data RAM, byte lanes and traps.
// Assumes the core drives requests synchronously to core_clk_i and that
// program memory and the data EEPROM answer combinationally.
`timescale 1ns/1ps
`include "mas_cfg.svh"

// How it works
// RULE_01: Program counter stays even and steps by two forward or back.
// RULE_02: Program words are 24 bits; upper byte of upper word reads zero.
// RULE_03: Lower program word at even address, upper word at next odd one.
// RULE_04: Vectors below 000200h; reset starts at 000000h, target at 000002h.
// RULE_05: Primary vector table 000004h-0000FFh, alternate 000104h-0001FFh.
// RULE_06: Data EEPROM 256x16 at 7FFE00, reached only by table operations.
// RULE_07: Data space is one linear 16-bit space with read and write generators.
// RULE_08: Data effective addresses are 16-bit byte addresses over 64 Kbytes.
// RULE_09: Top address bit clear selects RAM, set selects program window.
// RULE_10: 1024 RAM words implemented; reads outside return all zeros.
// RULE_11: Low byte of a word at even address, high byte at odd.
// RULE_12: Post-increment steps the pointer by one for bytes, two for words.
// RULE_13: Byte reads fetch the word, pick by bit zero, return on low lane.
// RULE_14: Shared word decode, separate byte strobes; byte writes hit one lane.
// RULE_15: Word accesses must be even; misaligned ones raise an address trap.
// RULE_16: Misaligned reads complete, misaligned writes are suppressed, then trap.
// RULE_17: Byte loads into a working register change only its low byte.
// RULE_18: Sign extend widens 8 to 16 bits; zero extend clears high byte.
// RULE_19: Near region 0000h-1FFFh reachable by 13-bit direct field.
// RULE_20: Full direct addressing carries a 16-bit field over the whole space.
// RULE_21: Program window answers only while its enable is set.
// RULE_22: Misaligned means address bit zero set on a word access.
module mas_access (
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_b_i,
   // Program counter control
   input  wire logic                     pc_inc_i,
   input  wire logic                     pc_dec_i,
   input  wire logic                     pc_load_i,
   input  wire logic [23:0]              pc_target_i,
   output logic      [23:0]              prog_addr_o,
   output logic                          pc_in_vec_o,
   output logic                          pc_in_ivt_o,
   output logic                          pc_in_aivt_o,
   // Instruction fetch
   input  wire logic [15:0]              prog_lo_i,
   input  wire logic [15:0]              prog_hi_i,
   output logic      [23:0]              instr_o,
   // Table access
   input  wire logic                     tbl_rd_i,
   input  wire logic                     tbl_wr_i,
   input  wire logic                     tbl_hi_i,
   input  wire logic [23:0]              tbl_addr_i,
   input  wire logic [15:0]              tbl_lo_i,
   input  wire logic [15:0]              tbl_hi_word_i,
   output logic      [15:0]              tbl_data_o,
   // Data EEPROM
   output logic                          ee_rd_o,
   output logic                          ee_wr_o,
   output logic      [7:0]               ee_idx_o,
   input  wire logic [15:0]              ee_data_i,
   // Program space window
   input  wire logic                     win_en_i,
   input  wire logic [7:0]               win_page_i,
   output logic      [23:0]              win_addr_o,
   input  wire logic [15:0]              win_data_i,
   // Read address generator
   input  wire logic                     rd_en_i,
   input  wire logic                     rd_byte_i,
   input  wire mas_pkg::mas_amode_t      rd_mode_i,
   input  wire logic [15:0]              rd_field_i,
   input  wire logic [15:0]              rd_ptr_i,
   output logic      [15:0]              rd_ptr_o,
   output logic      [15:0]              rd_data_o,
   output logic                          rd_valid_o,
   // Write address generator
   input  wire logic                     wr_en_i,
   input  wire logic                     wr_byte_i,
   input  wire mas_pkg::mas_amode_t      wr_mode_i,
   input  wire logic [15:0]              wr_field_i,
   input  wire logic [15:0]              wr_ptr_i,
   input  wire logic [15:0]              wr_data_i,
   output logic      [15:0]              wr_ptr_o,
   // Working register update
   input  wire logic                     wreg_en_i,
   input  wire mas_pkg::mas_wop_t        wreg_op_i,
   input  wire logic [15:0]              wreg_old_i,
   input  wire logic [15:0]              wreg_val_i,
   output logic      [15:0]              wreg_new_o,
   // Address error trap
   input  wire logic                     trap_ack_i,
   output logic                          addr_err_o
);

   // Effective address formation shared by both generators
   function automatic logic [15:0] ea_of(input mas_pkg::mas_amode_t mode,
                                         input logic [15:0] field,
                                         input logic [15:0] ptr);
      logic [15:0] ea;
      ea = ptr;
      case (mode)
         mas_pkg::AM_NEAR: ea = {3'h0, field[12:0]}; // see RULE_19
         mas_pkg::AM_FULL: ea = field;               // see RULE_20
         default:          ea = ptr;
      endcase
      return ea;
   endfunction

   logic [23:0]         pc_reg;
   logic [23:0]         pc_next;
   logic [23:0]         instr_reg;
   logic [15:0]         tbl_data_reg;
   logic [15:0]         rd_data_reg;
   logic [15:0]         rd_data_next;
   logic                rd_valid_reg;
   logic [15:0]         rd_ptr_reg;
   logic [15:0]         wr_ptr_reg;
   logic [15:0]         wreg_reg;
   logic [15:0]         wreg_next;
   mas_pkg::mas_trap_t  trap_reg;
   mas_pkg::mas_trap_t  trap_next;

   // Program counter next value; targets are forced to the lower word
   assign pc_next = pc_load_i ? {pc_target_i[23:1], 1'b0} :      // see RULE_01
                    pc_inc_i  ? pc_reg + `MAS_PC_STEP :          // see RULE_01
                    pc_dec_i  ? pc_reg - `MAS_PC_STEP : pc_reg;  // see RULE_01

   // Program counter, starting at the reset slot
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pc_reg <= `MAS_RESET_PC; // see RULE_04
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Vector region flags for the current fetch address
   assign prog_addr_o  = pc_reg;
   assign pc_in_vec_o  = pc_reg < `MAS_VEC_END;                            // see RULE_04
   assign pc_in_ivt_o  = (pc_reg >= `MAS_IVT_LO) && (pc_reg <= `MAS_IVT_HI);   // see RULE_05
   assign pc_in_aivt_o = (pc_reg >= `MAS_AIVT_LO) && (pc_reg <= `MAS_AIVT_HI); // see RULE_05

   // Table access decode; EEPROM only through table operations
   wire tbl_in_ee = (tbl_addr_i >= `MAS_EE_LO) && (tbl_addr_i <= `MAS_EE_HI);
   assign ee_rd_o  = tbl_rd_i && tbl_in_ee;  // see RULE_06
   assign ee_wr_o  = tbl_wr_i && tbl_in_ee;  // see RULE_06
   assign ee_idx_o = tbl_addr_i[8:1];        // see RULE_06

   // Upper word carries only the top instruction byte, phantom byte is zero
   wire [15:0] tbl_flash = tbl_hi_i ? {8'h00, tbl_hi_word_i[7:0]} : tbl_lo_i; // see RULE_02
   wire [15:0] tbl_rdata = tbl_in_ee ? ee_data_i : tbl_flash;

   // Fetch and table read registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         instr_reg    <= 24'h000000;
         tbl_data_reg <= 16'h0000;
      end else begin
         instr_reg <= {prog_hi_i[7:0], prog_lo_i}; // see RULE_02, see RULE_03
         if (tbl_rd_i) begin
            tbl_data_reg <= tbl_rdata;
         end
      end
   end

   assign instr_o    = instr_reg;
   assign tbl_data_o = tbl_data_reg;

   // Read and write address generators run independently
   wire [15:0] rd_ea = ea_of(rd_mode_i, rd_field_i, rd_ptr_i); // see RULE_07, see RULE_08
   wire [15:0] wr_ea = ea_of(wr_mode_i, wr_field_i, wr_ptr_i); // see RULE_07, see RULE_08
   wire [15:0] rd_step = rd_byte_i ? `MAS_BYTE_STEP : `MAS_WORD_STEP; // see RULE_12
   wire [15:0] wr_step = wr_byte_i ? `MAS_BYTE_STEP : `MAS_WORD_STEP; // see RULE_12
   wire rd_post = rd_en_i && (rd_mode_i == mas_pkg::AM_IND_POSTINC);
   wire wr_post = wr_en_i && (wr_mode_i == mas_pkg::AM_IND_POSTINC);

   // Region decode: low 1024 words to RAM, only reads of the high half to the window
   wire rd_in_ram = !rd_ea[15] && (rd_ea[15:1] < `MAS_RAM_WORDS); // see RULE_09, see RULE_10
   wire wr_in_ram = !wr_ea[15] && (wr_ea[15:1] < `MAS_RAM_WORDS); // see RULE_09, see RULE_10
   wire rd_in_win = rd_ea[15] && win_en_i;                         // see RULE_09, see RULE_21
   assign win_addr_o = {1'b0, win_page_i, rd_ea[14:0]};

   // Misaligned word accesses
   wire rd_mis = rd_en_i && !rd_byte_i && rd_ea[0]; // see RULE_22
   wire wr_mis = wr_en_i && !wr_byte_i && wr_ea[0]; // see RULE_22

   // Per-lane write strobes; lane 0 is the even byte
   wire [1:0] wr_lane;
   assign wr_lane[0] = wr_en_i && wr_in_ram && !wr_mis &&
                       (!wr_byte_i || !wr_ea[0]);       // see RULE_14, see RULE_16
   assign wr_lane[1] = wr_en_i && wr_in_ram && !wr_mis &&
                       (!wr_byte_i || wr_ea[0]);        // see RULE_14, see RULE_16
   wire [15:0] wr_lane_data = wr_byte_i ? {wr_data_i[7:0], wr_data_i[7:0]} : wr_data_i;
   wire [15:0] ram_word;

   // Two parallel byte lanes sharing one word index
   genvar gl;
   generate
      for (gl = 0; gl < 2; gl = gl + 1) begin : g_lane
         mas_byte_lane u_lane (
            .core_clk_i (core_clk_i),
            .wr_en_i    (wr_lane[gl]),
            .wr_idx_i   (wr_ea[10:1]),
            .wr_byte_i  (wr_lane_data[gl*8 +: 8]),
            .rd_idx_i   (rd_ea[10:1]),
            .rd_byte_o  (ram_word[gl*8 +: 8])
         ); // see RULE_11, see RULE_14
      end
   endgenerate

   // Read word select; unmapped or closed window reads zero
   wire [15:0] rd_word = rd_in_ram ? ram_word :
                         rd_in_win ? win_data_i : 16'h0000; // see RULE_10, see RULE_21
   wire [7:0]  rd_sel  = rd_ea[0] ? rd_word[15:8] : rd_word[7:0]; // see RULE_11
   assign rd_data_next = rd_byte_i ? {8'h00, rd_sel} : rd_word;   // see RULE_13

   // Read data and pointer write-back registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_reg  <= 16'h0000;
         rd_valid_reg <= 1'b0;
         rd_ptr_reg   <= 16'h0000;
         wr_ptr_reg   <= 16'h0000;
      end else begin
         rd_valid_reg <= rd_en_i; // see RULE_16
         if (rd_en_i) begin
            rd_data_reg <= rd_data_next;
         end
         rd_ptr_reg <= rd_post ? rd_ptr_i + rd_step : rd_ptr_i; // see RULE_12
         wr_ptr_reg <= wr_post ? wr_ptr_i + wr_step : wr_ptr_i; // see RULE_12
      end
   end

   assign rd_data_o  = rd_data_reg;
   assign rd_valid_o = rd_valid_reg;
   assign rd_ptr_o   = rd_ptr_reg;
   assign wr_ptr_o   = wr_ptr_reg;

   // Working register byte merge and extensions
   always_comb begin
      wreg_next = wreg_reg;
      if (wreg_en_i) begin
         case (wreg_op_i)
            mas_pkg::WOP_WORD: wreg_next = wreg_val_i;
            mas_pkg::WOP_BYTE: wreg_next = {wreg_old_i[15:8], wreg_val_i[7:0]};   // see RULE_17
            mas_pkg::WOP_SE:   wreg_next = {{8{wreg_old_i[7]}}, wreg_old_i[7:0]}; // see RULE_18
            mas_pkg::WOP_ZE:   wreg_next = {8'h00, wreg_old_i[7:0]};              // see RULE_18
            default:           wreg_next = wreg_val_i;
         endcase
      end
   end

   // Trap state: a new fault wins over an acknowledge in the same cycle
   always_comb begin
      trap_next = trap_reg;
      case (trap_reg)
         mas_pkg::TRAP_IDLE: begin
            if (rd_mis || wr_mis) begin
               trap_next = mas_pkg::TRAP_PEND; // see RULE_15
            end
         end
         mas_pkg::TRAP_PEND: begin
            if (trap_ack_i && !rd_mis && !wr_mis) begin
               trap_next = mas_pkg::TRAP_IDLE;
            end
         end
         default: trap_next = mas_pkg::TRAP_IDLE;
      endcase
   end

   // Working register and trap registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wreg_reg <= 16'h0000;
         trap_reg <= mas_pkg::TRAP_IDLE;
      end else begin
         wreg_reg <= wreg_next;
         trap_reg <= trap_next;
      end
   end

   assign wreg_new_o = wreg_reg;
   assign addr_err_o = (trap_reg == mas_pkg::TRAP_PEND);

   // Checks on the fetch, table, data, trap and working register paths
   property p_pc_step;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (pc_inc_i && !pc_load_i) |=> (pc_reg == $past(pc_reg) + `MAS_PC_STEP);
   endproperty
   a_pc_step: assert property (p_pc_step) // see RULE_01
      else $error("program counter did not step by two");

   property p_pc_even;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      pc_load_i |=> (prog_addr_o[0] == 1'b0);
   endproperty
   a_pc_even: assert property (p_pc_even) // see RULE_01
      else $error("program counter left lower word alignment");

   property p_phantom;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (tbl_rd_i && tbl_hi_i && !tbl_in_ee) |=> (tbl_data_o[15:8] == 8'h00);
   endproperty
   a_phantom: assert property (p_phantom) // see RULE_02
      else $error("phantom program byte read nonzero");

   property p_oor_zero;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (rd_en_i && !rd_in_ram && !(rd_ea[15] && win_en_i)) |=> (rd_data_o == 16'h0000);
   endproperty
   a_oor_zero: assert property (p_oor_zero) // see RULE_10
      else $error("unimplemented data read returned nonzero");

   property p_byte_low;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (rd_en_i && rd_byte_i) |=> (rd_data_o[15:8] == 8'h00) && rd_valid_o;
   endproperty
   a_byte_low: assert property (p_byte_low) // see RULE_13
      else $error("byte read not on low lane");

   property p_postinc;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (rd_post && rd_byte_i) |=> (rd_ptr_o == $past(rd_ptr_i) + `MAS_BYTE_STEP);
   endproperty
   a_postinc: assert property (p_postinc) // see RULE_12
      else $error("byte post-increment did not step by one");

   property p_trap_raise;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (rd_mis || wr_mis) |=> addr_err_o ##1 (addr_err_o || $past(trap_ack_i));
   endproperty
   a_trap_raise: assert property (p_trap_raise) // see RULE_15
      else $error("misaligned word access did not hold the trap");

   property p_wr_block;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      wr_mis |-> (wr_lane == 2'b00);
   endproperty
   a_wr_block: assert property (p_wr_block) // see RULE_16
      else $error("misaligned write reached memory");

   property p_byte_load;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (wreg_en_i && wreg_op_i == mas_pkg::WOP_BYTE) |=>
         (wreg_new_o[15:8] == $past(wreg_old_i[15:8]));
   endproperty
   a_byte_load: assert property (p_byte_load) // see RULE_17
      else $error("byte load disturbed high byte");

   property p_near;
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (rd_mode_i == mas_pkg::AM_NEAR) |-> (rd_ea <= `MAS_NEAR_HI);
   endproperty
   a_near: assert property (p_near) // see RULE_19
      else $error("near direct address left near region");

endmodule

/* File: dv/mas_mem_model.sv */
// Memory model for the far side: program flash, table words, data EEPROM and window data.
// Assumes combinational answers to the addresses that the access block presents.
`timescale 1ns/1ps

module mas_mem_model (
   // Addresses from the access block
   input  wire logic [23:0] prog_addr_i,
   input  wire logic [23:0] tbl_addr_i,
   input  wire logic [7:0]  ee_idx_i,
   input  wire logic [23:0] win_addr_i,
   // Memory words back to the block
   output logic      [15:0] prog_lo_o,
   output logic      [15:0] prog_hi_o,
   output logic      [15:0] tbl_lo_o,
   output logic      [15:0] tbl_hi_word_o,
   output logic      [15:0] ee_data_o,
   output logic      [15:0] win_data_o
);
   // Address-derived patterns; phantom bytes are non-zero so zeroing shows
   assign prog_lo_o     = prog_addr_i[15:0] ^ 16'h1234;
   assign prog_hi_o     = {8'hC3, prog_addr_i[7:0] ^ 8'h5A};
   assign tbl_lo_o      = tbl_addr_i[15:0] ^ 16'h0F0F;
   assign tbl_hi_word_o = {8'h99, tbl_addr_i[7:0]};
   assign ee_data_o     = {ee_idx_i, ~ee_idx_i};
   assign win_data_o    = win_addr_i[15:0] ^ 16'h3C5A;
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the address space access block.
// Assumes the memory model answers combinationally; inputs change at falling edges.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
   // Clock, reset and stimulus
   logic core_clk_i = 1'b0;
   logic rst_b_i    = 1'b0;
   logic pc_inc_i, pc_dec_i, pc_load_i, tbl_rd_i, tbl_wr_i, tbl_hi_i, win_en_i;
   logic rd_en_i, rd_byte_i, wr_en_i, wr_byte_i, wreg_en_i, trap_ack_i;
   logic pc_in_vec_o, pc_in_ivt_o, pc_in_aivt_o, ee_rd_o, ee_wr_o, rd_valid_o, addr_err_o;
   logic [23:0] pc_target_i, tbl_addr_i, prog_addr_o, instr_o, win_addr_o;
   logic [15:0] prog_lo_i, prog_hi_i, tbl_lo_i, tbl_hi_word_i, tbl_data_o, ee_data_i;
   logic [15:0] win_data_i, rd_field_i, rd_ptr_i, rd_ptr_o, rd_data_o, wr_field_i;
   logic [15:0] wr_ptr_i, wr_data_i, wr_ptr_o, wreg_old_i, wreg_val_i, wreg_new_o;
   logic [7:0]  ee_idx_o, win_page_i;
   mas_pkg::mas_amode_t rd_mode_i, wr_mode_i;
   mas_pkg::mas_wop_t   wreg_op_i;
   logic [15:0] ram [0:1023];
   logic [23:0] va [0:6] = '{24'h0, 24'h4, 24'hFE, 24'h100, 24'h104, 24'h1FE, 24'h200};
   logic [31:0] r;
   integer      seed = 32'h611F;
   int          fails, n_compared, cycles, i;

   mas_access mas_access_inst (.core_clk_i, .rst_b_i, .pc_inc_i, .pc_dec_i, .pc_load_i,
      .pc_target_i, .prog_addr_o, .pc_in_vec_o, .pc_in_ivt_o, .pc_in_aivt_o, .prog_lo_i,
      .prog_hi_i, .instr_o, .tbl_rd_i, .tbl_wr_i, .tbl_hi_i, .tbl_addr_i, .tbl_lo_i,
      .tbl_hi_word_i, .tbl_data_o, .ee_rd_o, .ee_wr_o, .ee_idx_o, .ee_data_i, .win_en_i,
      .win_page_i, .win_addr_o, .win_data_i, .rd_en_i, .rd_byte_i, .rd_mode_i, .rd_field_i,
      .rd_ptr_i, .rd_ptr_o, .rd_data_o, .rd_valid_o, .wr_en_i, .wr_byte_i, .wr_mode_i,
      .wr_field_i, .wr_ptr_i, .wr_data_i, .wr_ptr_o, .wreg_en_i, .wreg_op_i, .wreg_old_i,
      .wreg_val_i, .wreg_new_o, .trap_ack_i, .addr_err_o);

   mas_mem_model mas_mem_model_inst (.prog_addr_i(prog_addr_o), .tbl_addr_i(tbl_addr_i),
      .ee_idx_i(ee_idx_o), .win_addr_i(win_addr_o), .prog_lo_o(prog_lo_i),
      .prog_hi_o(prog_hi_i), .tbl_lo_o(tbl_lo_i), .tbl_hi_word_o(tbl_hi_word_i),
      .ee_data_o(ee_data_i), .win_data_o(win_data_i));

   // Clock and hang guard
   always #25 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         tally_and_finish();
      end
   end

   // Expected read data from the reference RAM, window and range rules
   function automatic logic [15:0] exp_rd(input logic b, input logic [15:0] ea);
      logic [15:0] w;
      w = 16'h0000;
      if (ea[15] && win_en_i) w = {win_page_i[0], ea[14:0]} ^ 16'h3C5A;
      if (!ea[15] && ea < 16'h0800) w = ram[ea[10:1]];
      if (b) w = {8'h00, ea[0] ? w[15:8] : w[7:0]};
      return w;
   endfunction

   // Expected working register result
   function automatic logic [15:0] exp_wreg(input int op, input logic [15:0] o, v);
      if (op == 0) return v;
      if (op == 1) return {o[15:8], v[7:0]};
      if (op == 2) return {{8{o[7]}}, o[7:0]};
      return {8'h00, o[7:0]};
   endfunction

   task automatic cyc();
      @(negedge core_clk_i);
   endtask

   task automatic rd(input logic b, input logic [15:0] a, input logic [1:0] m);
      logic [15:0] e;
      rd_en_i = 1'b1;
      rd_byte_i = b;
      rd_mode_i = mas_pkg::mas_amode_t'(m);
      rd_field_i = a;
      rd_ptr_i = a;
      e = exp_rd(b, (m == 2'd0) ? {3'h0, a[12:0]} : a);
      cyc();
      `CHK(rd_data_o, e)
      `CHK(rd_valid_o, 1'b1)
      `CHK(rd_ptr_o, a + ((m == 2'd3) ? (b ? 16'h1 : 16'h2) : 16'h0))
      rd_en_i = 1'b0;
      cyc();
   endtask

   task automatic wr(input logic b, input logic [15:0] a, d, input logic [1:0] m);
      wr_en_i = 1'b1;
      wr_byte_i = b;
      wr_mode_i = mas_pkg::mas_amode_t'(m);
      wr_field_i = a;
      wr_ptr_i = a;
      wr_data_i = d;
      if (b && a[0]) ram[a[10:1]][15:8] = d[7:0];
      else if (b) ram[a[10:1]][7:0] = d[7:0];
      else if (!a[0]) ram[a[10:1]] = d;
      cyc();
      `CHK(wr_ptr_o, a + ((m == 2'd3) ? (b ? 16'h1 : 16'h2) : 16'h0))
      wr_en_i = 1'b0;
      cyc();
   endtask

   task automatic ack();
      trap_ack_i = 1'b1;
      cyc();
      trap_ack_i = 1'b0;
      `CHK(addr_err_o, 1'b0)
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {pc_inc_i, pc_dec_i, pc_load_i, tbl_rd_i, tbl_wr_i, tbl_hi_i, win_en_i} = '0;
      {rd_en_i, rd_byte_i, wr_en_i, wr_byte_i, wreg_en_i, trap_ack_i} = '0;
      {pc_target_i, tbl_addr_i, rd_field_i, rd_ptr_i, wr_field_i, wr_ptr_i} = '0;
      {wr_data_i, wreg_old_i, wreg_val_i, win_page_i} = '0;
      rd_mode_i = mas_pkg::AM_NEAR;
      wr_mode_i = mas_pkg::AM_NEAR;
      wreg_op_i = mas_pkg::WOP_WORD;
      repeat (12) cyc();
      rst_b_i = 1'b1;
      `CHK(prog_addr_o, 24'h0)
      // Program counter steps and vector region flags
      for (i = 0; i < 7; i++) begin
         pc_load_i = 1'b1;
         pc_target_i = va[i] | 24'h1;
         cyc();
         pc_load_i = 1'b0;
         `CHK(prog_addr_o, va[i])
         `CHK(pc_in_vec_o, va[i] < 24'h200)
         `CHK(pc_in_ivt_o, va[i] >= 24'h4 && va[i] <= 24'hFF)
         `CHK(pc_in_aivt_o, va[i] >= 24'h104 && va[i] <= 24'h1FF)
         cyc();
         `CHK(instr_o, {va[i][7:0] ^ 8'h5A, va[i][15:0] ^ 16'h1234})
      end
      pc_inc_i = 1'b1;
      cyc();
      `CHK(prog_addr_o, 24'h202)
      pc_dec_i = 1'b1;
      cyc();
      `CHK(prog_addr_o, 24'h204)
      pc_inc_i = 1'b0;
      cyc();
      pc_dec_i = 1'b0;
      `CHK(prog_addr_o, 24'h202)
      $display("test program counter done");
      // Table reads of flash and EEPROM, EEPROM writes
      tbl_rd_i = 1'b1;
      tbl_addr_i = 24'h000011;
      cyc();
      `CHK(tbl_data_o, 16'h0011 ^ 16'h0F0F)
      tbl_hi_i = 1'b1;
      cyc();
      `CHK(tbl_data_o, 16'h0011)
      tbl_addr_i = 24'h7FFE06;
      #1 `CHK(ee_rd_o, 1'b1)
      `CHK(ee_idx_o, 8'h03)
      cyc();
      `CHK(tbl_data_o, 16'h03FC)
      tbl_rd_i = 1'b0;
      tbl_wr_i = 1'b1;
      #1 `CHK(ee_wr_o, 1'b1)
      cyc();
      tbl_addr_i = 24'h000010;
      #1 `CHK(ee_wr_o, 1'b0)
      cyc();
      tbl_wr_i = 1'b0;
      $display("test table access done");
      // Fill, then random byte and word traffic through every mode
      for (i = 0; i < 32; i++) begin
         r = $random(seed);
         wr(1'b0, 16'(i * 2), r[15:0], 2'(i));
      end
      for (i = 0; i < 150; i++) begin
         r = $random(seed);
         if (r[7]) wr(r[6], {10'h0, r[5:1], r[0] & r[6]}, r[31:16], r[9:8]);
         else rd(r[6], {10'h0, r[5:1], r[0] & r[6]}, r[9:8]);
      end
      `CHK(addr_err_o, 1'b0)
      rd(1'b0, 16'hE004, 2'd0);
      $display("test data traffic done");
      // Out of range and program window
      rd(1'b0, 16'h0800, 2'd1);
      rd(1'b1, 16'h7FFF, 2'd2);
      rd(1'b0, 16'h8010, 2'd1);
      win_en_i = 1'b1;
      win_page_i = 8'h81;
      rd(1'b1, 16'h8011, 2'd1);
      `CHK(win_addr_o, {1'b0, 8'h81, 15'h0011})
      win_en_i = 1'b0;
      $display("test ranges done");
      // Misaligned write suppressed, misaligned read completes; both trap
      wr(1'b0, 16'h0005, 16'hDEAD, 2'd1);
      `CHK(addr_err_o, 1'b1)
      rd(1'b0, 16'h0004, 2'd1);
      ack();
      rd(1'b0, 16'h0007, 2'd3);
      `CHK(addr_err_o, 1'b1)
      ack();
      $display("test traps done");
      // Working register updates for every operation
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         wreg_en_i = 1'b1;
         wreg_op_i = mas_pkg::mas_wop_t'(i % 4);
         wreg_old_i = r[15:0];
         wreg_val_i = r[31:16];
         cyc();
         `CHK(wreg_new_o, exp_wreg(i % 4, r[15:0], r[31:16]))
      end
      wreg_en_i = 1'b0;
      $display("test working register done");
      tally_and_finish();
   end
endmodule
